// >>> hw/byte_fifo.v
// parameterised valid/ready FIFO for the transmit data path
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_ff;
	reg [AW-1:0]    rd_ptr_ff;
	reg [AW:0]      count_ff;
	wire            push;
	wire            pop;

	assign in_ready  = (count_ff != DEPTH[AW:0]);
	assign out_valid = (count_ff != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge pclk) begin
		if (push)
			mem[wr_ptr_ff] <= in_data;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
			if (push & ~pop)
				count_ff <= count_ff + 1'b1;
			else if (pop & ~push)
				count_ff <= count_ff - 1'b1;
		end
	end
endmodule // byte_fifo

// >>> hw/serial_format_channel.v
// serial channel: format register, prescaler, transmitter and receiver behind APB
// Notes on behaviour
// RULE1: bit 7 picks asynchronous or clocked synchronous
// RULE2: async bit 6 picks 8 or 7 bits
// RULE3: 7-bit sends LSB first, drops buffer MSB
// RULE4: synchronous mode always uses 8 bits
// RULE5: async bit 5 adds and checks parity
// RULE6: address-flag format disables parity entirely
// RULE7: bit 4 picks even or odd parity
// RULE8: async bit 3 sends one or two stops
// RULE9: receiver checks first stop only
// RULE10: bit 2 enables address-flag format
// RULE11: bits 1:0 divide clock by 1,4,16,64
// RULE12: layout valid only with card select zero
// RULE13: all fields reset zero, read/write
`include "serial_format_defs.vh"
module serial_format_channel #(
	parameter FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        rxd,
	output wire        txd,
	output wire        sck_out,
	output wire        sck_oe,
	input  wire        sck_in
);
	localparam TX_IDLE = 3'h0;
	localparam TX_START = 3'h1;
	localparam TX_DATA = 3'h2;
	localparam TX_PAR = 3'h3;
	localparam TX_STOP = 3'h4;
	localparam RX_IDLE = 3'h0;
	localparam RX_START = 3'h1;
	localparam RX_DATA = 3'h2;
	localparam RX_PAR = 3'h3;
	localparam RX_STOP = 3'h4;

	reg  [7:0]  fmt_ff;
	reg  [7:0]  card_mode_ff;
	reg  [7:0]  bit_rate_ff;
	reg  [7:0]  rx_data_ff;
	reg         rx_full_ff;
	reg         par_err_ff;
	reg         frm_err_ff;
	reg         ovr_err_ff;
	reg         mpb_ff;
	wire        wr_en;
	wire        rd_en;
	wire        addr_ok;

	// decoded format
	wire        card_if;
	wire        sync_mode;
	wire [3:0]  nbits;
	wire        par_used;
	wire        par_odd;
	wire        two_stop;
	wire        addr_fmt;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign addr_ok = (paddr == `OFS_FORMAT_CTRL) | (paddr == `OFS_CARD_MODE) |
	                 (paddr == `OFS_TX_DATA) | (paddr == `OFS_RX_DATA) |
	                 (paddr == `OFS_STATUS) | (paddr == `OFS_BIT_RATE);
	assign pslverr = psel & penable & ~addr_ok;

	// RULE12: card select gates layout
	assign card_if   = card_mode_ff[`FLD_CARD_IF];
	// RULE1: mode select bit
	assign sync_mode = fmt_ff[`FLD_SYNC_MODE] & ~card_if;
	// RULE2: RULE4: length chosen in async only
	assign nbits     = (!sync_mode && fmt_ff[`FLD_WORD_SIZE] && !card_if) ? 4'd7 : 4'd8;
	// RULE10: address-flag format in async only
	assign addr_fmt  = fmt_ff[`FLD_ADDR_FLAG] & ~sync_mode & ~card_if;
	// RULE5: RULE6: parity only without address-flag format
	assign par_used  = fmt_ff[`FLD_PARITY_EN] & ~sync_mode & ~addr_fmt & ~card_if;
	// RULE7: parity sense
	assign par_odd   = fmt_ff[`FLD_PARITY_ODD];
	// RULE8: stop count in async
	assign two_stop  = fmt_ff[`FLD_TWO_STOP] & ~sync_mode & ~card_if;

	// transmit FIFO
	wire        fifo_in_ready;
	wire [8:0]  fifo_out_data;
	wire        fifo_out_valid;
	reg         fifo_pop;
	wire        tx_wr;
	assign tx_wr = wr_en & (paddr == `OFS_TX_DATA);

	byte_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) u_tx_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_data   ({pwdata[8], pwdata[7:0]}),
		.in_valid  (tx_wr),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop)
	);

	// RULE11: prescaler select function
	function [6:0] presc_limit;
		input [1:0] sel;
		begin
			case (sel)
				2'b00:   presc_limit = 7'd0;
				2'b01:   presc_limit = 7'd3;
				2'b10:   presc_limit = 7'd15;
				default: presc_limit = 7'd63;
			endcase
		end
	endfunction

	reg  [6:0]  presc_ff;
	reg  [7:0]  rate_ff;
	reg  [3:0]  os_ff;
	wire        presc_tick;
	wire        rate_tick;
	wire        bit_tick;
	// RULE11: prescaler divides phi
	assign presc_tick = (presc_ff == presc_limit({fmt_ff[`FLD_PRESC_HI], fmt_ff[`FLD_PRESC_LO]}));
	assign rate_tick  = presc_tick & (rate_ff == bit_rate_ff);
	// async bit time is 16 rate ticks; sync uses every rate tick as a half period
	assign bit_tick   = rate_tick & (sync_mode | (os_ff == 4'hF));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_ff <= 7'd0;
			rate_ff  <= 8'h00;
			os_ff    <= 4'h0;
		end else begin
			presc_ff <= presc_tick ? 7'd0 : presc_ff + 7'd1;
			if (presc_tick)
				rate_ff <= (rate_ff == bit_rate_ff) ? 8'h00 : rate_ff + 8'h01;
			if (rate_tick)
				os_ff <= os_ff + 4'h1;
		end
	end

	// synchronisers for pins
	reg  [1:0]  rxd_sync_ff;
	reg  [1:0]  sck_sync_ff;
	reg         sck_prev_ff;
	wire        rxd_s;
	assign rxd_s = rxd_sync_ff[1];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_sync_ff <= 2'b11;
			sck_sync_ff <= 2'b11;
			sck_prev_ff <= 1'b1;
		end else begin
			rxd_sync_ff <= {rxd_sync_ff[0], rxd};
			sck_sync_ff <= {sck_sync_ff[0], sck_in};
			sck_prev_ff <= sck_sync_ff[1];
		end
	end

	// transmitter
	reg  [2:0]  tx_st_ff;
	reg  [7:0]  tx_sh_ff;
	reg  [3:0]  tx_cnt_ff;
	reg         tx_par_ff;
	reg         tx_mpb_ff;
	reg         txd_ff;
	reg         sck_ff;
	reg         tx_phase_ff;
	assign txd     = txd_ff;
	assign sck_out = sck_ff;
	assign sck_oe  = sync_mode;

	// next word loads as the last stop bit ends, so back-to-back frames leave no idle bit
	always @* begin
		fifo_pop = fifo_out_valid & bit_tick & ~tx_phase_ff &
		           ((tx_st_ff == TX_IDLE) |
		            ((tx_st_ff == TX_STOP) & ~(two_stop & (tx_cnt_ff == 4'h0))));
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_ff    <= TX_IDLE;
			tx_sh_ff    <= 8'h00;
			tx_cnt_ff   <= 4'h0;
			tx_par_ff   <= 1'b0;
			tx_mpb_ff   <= 1'b0;
			txd_ff      <= 1'b1;
			sck_ff      <= 1'b1;
			tx_phase_ff <= 1'b0;
		end else if (bit_tick) begin
			// phase cleared outside sync mode, a stale phase would block async loads
			tx_phase_ff <= sync_mode & ~tx_phase_ff;
			case (tx_st_ff)
				TX_IDLE: begin
					txd_ff <= 1'b1;
					sck_ff <= 1'b1;
				end
				TX_START: begin
					// RULE3: LSB first transmission
					txd_ff    <= tx_sh_ff[0];
					tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
					tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
					tx_cnt_ff <= 4'h1;
					tx_st_ff  <= TX_DATA;
				end
				TX_DATA: begin
					if (sync_mode && tx_phase_ff) begin
						// sync clock rises mid-bit while txd stands still
						sck_ff <= 1'b1;
					end else begin
						// RULE3: RULE2: stop after nbits, MSB dropped
						if (tx_cnt_ff == nbits) begin
							if (par_used) begin
								txd_ff   <= tx_par_ff;
								tx_st_ff <= TX_PAR;
							end else if (addr_fmt) begin
								txd_ff   <= tx_mpb_ff;
								tx_st_ff <= TX_PAR;
							end else if (sync_mode) begin
								tx_st_ff <= TX_IDLE;
							end else begin
								txd_ff    <= 1'b1;
								tx_cnt_ff <= 4'h0;
								tx_st_ff  <= TX_STOP;
							end
						end else begin
							sck_ff    <= ~sync_mode;
							txd_ff    <= tx_sh_ff[0];
							tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
							tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
							tx_cnt_ff <= tx_cnt_ff + 4'h1;
						end
					end
				end
				TX_PAR: begin
					txd_ff    <= 1'b1;
					tx_cnt_ff <= 4'h0;
					tx_st_ff  <= TX_STOP;
				end
				TX_STOP: begin
					// RULE8: one or two stop bits
					if (two_stop && tx_cnt_ff == 4'h0)
						tx_cnt_ff <= 4'h1;
					else
						tx_st_ff <= TX_IDLE;
				end
				default: tx_st_ff <= TX_IDLE;
			endcase
			if (fifo_pop) begin
				// sync frames have no start bit: first data bit and falling clock go out now
				tx_mpb_ff <= fifo_out_data[8];
				tx_par_ff <= par_odd;
				tx_cnt_ff <= sync_mode ? 4'h1 : 4'h0;
				tx_st_ff  <= sync_mode ? TX_DATA : TX_START;
				txd_ff    <= sync_mode ? fifo_out_data[0] : 1'b0;
				sck_ff    <= ~sync_mode;
				tx_sh_ff  <= sync_mode ? {1'b0, fifo_out_data[7:1]} : fifo_out_data[7:0];
			end
		end
	end

	// receiver, async samples mid-bit with 16x oversampling
	reg  [2:0]  rx_st_ff;
	reg  [3:0]  rx_os_ff;
	reg  [3:0]  rx_cnt_ff;
	reg  [7:0]  rx_sh_ff;
	reg         rx_par_ff;
	reg         rx_mpb_ff;
	reg         rx_done;
	reg         rx_perr;
	reg         rx_ferr;
	wire        rx_mid;
	wire        sck_rise;
	wire        rx_smp;
	assign rx_mid   = rate_tick & (rx_os_ff == 4'h7);
	assign sck_rise = sck_sync_ff[1] & ~sck_prev_ff;
	assign rx_smp   = sync_mode ? sck_rise : rx_mid;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_ff  <= RX_IDLE;
			rx_os_ff  <= 4'h0;
			rx_cnt_ff <= 4'h0;
			rx_sh_ff  <= 8'h00;
			rx_par_ff <= 1'b0;
			rx_mpb_ff <= 1'b0;
			rx_done   <= 1'b0;
			rx_perr   <= 1'b0;
			rx_ferr   <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (rate_tick)
				rx_os_ff <= rx_os_ff + 4'h1;
			case (rx_st_ff)
				RX_IDLE: begin
					rx_cnt_ff <= 4'h0;
					rx_par_ff <= par_odd;
					rx_mpb_ff <= 1'b0;
					if (sync_mode && sck_rise) begin
						rx_sh_ff  <= {rxd_s, rx_sh_ff[7:1]};
						rx_cnt_ff <= 4'h1;
						rx_st_ff  <= RX_DATA;
					end else if (!sync_mode && !rxd_s) begin
						rx_os_ff <= 4'h0;
						rx_st_ff <= RX_START;
					end
				end
				RX_START: begin
					if (rx_mid)
						rx_st_ff <= rxd_s ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					if (rx_smp) begin
						rx_sh_ff  <= {rxd_s, rx_sh_ff[7:1]};
						rx_par_ff <= rx_par_ff ^ rxd_s;
						rx_cnt_ff <= rx_cnt_ff + 4'h1;
						if (rx_cnt_ff + 4'h1 == nbits) begin
							if (sync_mode) begin
								rx_done  <= 1'b1;
								rx_perr  <= 1'b0;
								rx_ferr  <= 1'b0;
								rx_st_ff <= RX_IDLE;
							end else begin
								rx_st_ff <= (par_used | addr_fmt) ? RX_PAR : RX_STOP;
							end
						end
					end
				end
				RX_PAR: begin
					if (rx_mid) begin
						rx_par_ff <= rx_par_ff ^ rxd_s;
						rx_mpb_ff <= rxd_s;
						rx_st_ff  <= RX_STOP;
					end
				end
				RX_STOP: begin
					// RULE9: only first stop checked
					if (rx_mid) begin
						rx_done  <= 1'b1;
						// RULE5: RULE6: parity check skipped in address-flag format
						rx_perr  <= par_used & rx_par_ff;
						rx_ferr  <= ~rxd_s;
						rx_st_ff <= RX_IDLE;
					end
				end
				default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	wire [7:0] rx_word;
	// RULE2: 7-bit word is right-aligned
	assign rx_word = (nbits == 4'd7) ? {1'b0, rx_sh_ff[7:1]} : rx_sh_ff;

	wire rx_rd;
	wire st_wr;
	assign rx_rd = rd_en & (paddr == `OFS_RX_DATA);
	assign st_wr = wr_en & (paddr == `OFS_STATUS);

	// register file
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// RULE13: fields reset to zero
			fmt_ff       <= `RST_FORMAT_CTRL;
			card_mode_ff <= `RST_CARD_MODE;
			bit_rate_ff  <= `RST_BIT_RATE;
			rx_data_ff   <= 8'h00;
			rx_full_ff   <= 1'b0;
			par_err_ff   <= 1'b0;
			frm_err_ff   <= 1'b0;
			ovr_err_ff   <= 1'b0;
			mpb_ff       <= 1'b0;
		end else begin
			// RULE13: software read/write
			if (wr_en && paddr == `OFS_FORMAT_CTRL)
				fmt_ff <= pwdata[7:0];
			if (wr_en && paddr == `OFS_CARD_MODE)
				card_mode_ff <= pwdata[7:0];
			if (wr_en && paddr == `OFS_BIT_RATE)
				bit_rate_ff <= pwdata[7:0];
			// set wins over clear
			if (rx_done) begin
				if (rx_full_ff && !rx_rd)
					ovr_err_ff <= 1'b1;
				else begin
					rx_data_ff <= rx_word;
					mpb_ff     <= rx_mpb_ff;
				end
				rx_full_ff <= 1'b1;
				par_err_ff <= par_err_ff | rx_perr;
				frm_err_ff <= frm_err_ff | rx_ferr;
			end else begin
				if (rx_rd)
					rx_full_ff <= 1'b0;
				if (st_wr) begin
					par_err_ff <= par_err_ff & ~pwdata[3];
					frm_err_ff <= frm_err_ff & ~pwdata[4];
					ovr_err_ff <= ovr_err_ff & ~pwdata[5];
				end
			end
		end
	end

	always @* begin
		prdata = 32'h00000000;
		case (paddr)
			`OFS_FORMAT_CTRL: prdata = {24'h000000, fmt_ff};
			`OFS_CARD_MODE:   prdata = {24'h000000, card_mode_ff};
			`OFS_RX_DATA:     prdata = {24'h000000, rx_data_ff};
			`OFS_BIT_RATE:    prdata = {24'h000000, bit_rate_ff};
			`OFS_STATUS:      prdata = {26'h0000000, ovr_err_ff, frm_err_ff, par_err_ff,
			                            rx_full_ff, mpb_ff, fifo_in_ready};
			default:          prdata = 32'h00000000;
		endcase
	end
endmodule // serial_format_channel

// >>> hw/serial_format_defs.vh
// register offsets, field positions, reset values and timing counts of the serial format block
`ifndef SERIAL_FORMAT_DEFS_VH
`define SERIAL_FORMAT_DEFS_VH

`define OFS_FORMAT_CTRL      12'h000
`define OFS_CARD_MODE        12'h004
`define OFS_TX_DATA          12'h008
`define OFS_RX_DATA          12'h00C
`define OFS_STATUS           12'h010
`define OFS_BIT_RATE         12'h014

`define FLD_SYNC_MODE        7
`define FLD_WORD_SIZE        6
`define FLD_PARITY_EN        5
`define FLD_PARITY_ODD       4
`define FLD_TWO_STOP         3
`define FLD_ADDR_FLAG        2
`define FLD_PRESC_HI         1
`define FLD_PRESC_LO         0
`define FLD_CARD_IF          0

`define RST_FORMAT_CTRL      8'h00
`define RST_CARD_MODE        8'h00
`define RST_BIT_RATE         8'hFF

`define FIFO_DEPTH_DEF       8
`define RX_SAMPLE_DIV        16

`endif

// >>> testbench/serial_format_chk.sv
// checker of register and pin relations of the serial format channel
module serial_format_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        sck_out,
	input wire logic        sck_oe,
	input wire logic        sck_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] fmt_ff;
	logic       card_ff;
	wire logic  acc = psel & penable;
	// shadow of what software wrote, to judge readback and pin enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt_ff <= 8'h00;
			card_ff <= 1'b0;
		end else if (acc && pwrite && paddr == 12'h000) begin
			fmt_ff <= pwdata[7:0];
		end else if (acc && pwrite && paddr == 12'h004) begin
			card_ff <= pwdata[0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_unmapped_err: assert property (acc && paddr > 12'h014 |-> pslverr)
		else $error("no error on unmapped access");
	a_unmapped_zero: assert property (acc && !pwrite && paddr > 12'h014 |-> ##0 prdata == 32'h0)
		else $error("unmapped read not zero");
	a_mapped_ok: assert property (acc && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped access");
	a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_fmt_readback: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[7:0] == fmt_ff)
		else $error("format readback wrong");
	a_card_readback: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata[0] == card_ff)
		else $error("card select readback wrong");
	a_clk_enable: assert property (sck_oe == (fmt_ff[7] & ~card_ff))
		else $error("clock enable does not follow mode");
	a_idle_reset: assert property ($rose(presetn) |-> txd && sck_out && !sck_oe)
		else $error("pins not idle after reset");
	c_fmt_write: cover property (acc && pwrite && paddr == 12'h000);
	c_unmapped: cover property (acc && pslverr);
	c_sync: cover property ($rose(sck_oe));
endmodule // serial_format_chk

bind serial_format_channel serial_format_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .sck_out(sck_out),
	.sck_oe(sck_oe), .sck_in(sck_in));

// >>> testbench/serial_peer.sv
// model of the remote serial device on the line
module serial_peer (
	input  wire logic pclk,
	input  wire logic txd,
	input  wire logic sck_out,
	output logic      rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	int          bt = 16;
	int          nb = 10;
	bit          en = 0;
	logic [11:0] f;
	logic [11:0] q[$];
	initial rxd = 1'b1;
	// sample each bit in its middle
	always begin
		@(negedge txd);
		if (en) begin
			f = 12'h000;
			repeat (bt / 2) @(posedge pclk);
			for (int i = 0; i < nb; i++) begin
				f[i] = txd;
				// stop after the last sample so a back-to-back start edge is not missed
				if (i < nb - 1) repeat (bt) @(posedge pclk);
			end
			q.push_back(f);
		end
	end
	// frames end on a stop bit, so the line rests high
	task send(input logic [11:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= v[i];
			repeat (bt) @(posedge pclk);
		end
	endtask
	task get_sync(output logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(posedge sck_out);
			d[i] = txd;
		end
	endtask
endmodule // serial_peer

// >>> testbench/tb.sv
// self-checking bench of the serial format channel
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] f; logic c; logic [8:0] d; logic [11:0] e; int n; int b;} fc_t;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, re;
	logic [11:0] paddr = 12'h000, fr;
	logic [31:0] pwdata = 32'h0, prdata, rq = 32'h0;
	logic [7:0]  sd;
	logic        pready, pslverr, rxd, txd, sck_out, sck_oe;
	int          errors = 0, num_checks = 0;
	fc_t cs[8] = '{'{8'h00, 0, 9'h035, 12'h26A, 10, 16}, '{8'h40, 0, 9'h045, 12'h18A, 9, 16},
		'{8'h20, 0, 9'h007, 12'h60E, 11, 16}, '{8'h30, 0, 9'h007, 12'h40E, 11, 16},
		'{8'h08, 0, 9'h035, 12'h66A, 12, 16}, '{8'h24, 0, 9'h103, 12'h606, 11, 16},
		'{8'h01, 0, 9'h035, 12'h26A, 10, 64}, '{8'h48, 1, 9'h0C5, 12'h38A, 11, 16}};
	serial_format_channel uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .txd(txd), .sck_out(sck_out), .sck_oe(sck_oe),
		.sck_in(sck_out));
	serial_peer peer (.pclk(pclk), .txd(txd), .sck_out(sck_out), .rxd(rxd));
	initial forever #2.5 pclk = ~pclk;
	initial begin
		repeat (30000) @(posedge pclk);
		errors++;
		test_done;
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task rx_frame;
		for (int w = 0; w < 4000 && peer.q.size() == 0; w++) @(posedge pclk);
		fr = peer.q.size() ? peer.q.pop_front() : 12'hXXX;
	endtask
	task poll(input int b);
		for (int w = 0; w < 500; w++) begin
			apb(0, 12'h010, 0);
			if (rq[b] === 1'b1) break;
		end
	endtask
	task t_reset;
		apb(0, 12'h000, 0);
		chk("format", 0, rq);
		apb(0, 12'h004, 0);
		chk("card", 0, rq);
		apb(0, 12'h014, 0);
		chk("rate", 32'hFF, rq);
	endtask
	task t_regs;
		apb(1, 12'h000, 32'hA5);
		apb(0, 12'h000, 0);
		chk("format rw", 32'hA5, rq);
		apb(1, 12'h03C, 32'h55);
		chk("bad err", 1, 32'(re));
		apb(1, 12'h000, 0);
		apb(1, 12'h014, 0);
	endtask
	task t_formats;
		peer.en = 1;
		for (int i = 0; i < 8; i++) begin
			apb(1, 12'h004, 32'(cs[i].c));
			apb(1, 12'h000, 32'(cs[i].f));
			peer.nb = cs[i].n;
			peer.bt = cs[i].b;
			apb(1, 12'h008, 32'(cs[i].d));
			// a second word shows where the stop bits end
			if (cs[i].f[3]) apb(1, 12'h008, 32'(cs[i].d));
			rx_frame;
			chk("frame", 32'(cs[i].e), 32'(fr));
			repeat (400) @(posedge pclk);
			peer.q.delete();
		end
		apb(1, 12'h004, 0);
	endtask
	task t_sync;
		peer.en = 0;
		apb(1, 12'h000, 32'hC0);
		fork
			peer.get_sync(sd);
			apb(1, 12'h008, 32'hA6);
		join
		chk("sync", 32'hA6, 32'(sd));
		repeat (40) @(posedge pclk);
		// clock looped back, idle line must give eight ones
		apb(0, 12'h00C, 0);
		chk("sync rx", 32'hFF, rq);
		apb(1, 12'h000, 0);
		peer.en = 1;
	endtask
	task t_fifo;
		int k;
		k = 0;
		peer.nb = 10;
		apb(0, 12'h010, 0);
		while (rq[0] === 1'b1 && k < 12) begin
			apb(1, 12'h008, 32'h10 + k);
			k++;
			apb(0, 12'h010, 0);
		end
		chk("full", 0, 32'(rq[0]));
		chk("depth", 1, 32'(k >= 8));
		apb(1, 12'h008, 32'hEE);
		for (int i = 0; i < k; i++) begin
			rx_frame;
			chk("drain", 32'h200 | ((32'h10 + i) << 1), 32'(fr));
		end
		repeat (200) @(posedge pclk);
		chk("extra", 0, peer.q.size());
		apb(0, 12'h010, 0);
		chk("not full", 1, 32'(rq[0]));
	endtask
	task t_rx;
		apb(1, 12'h000, 32'h28);
		fork
			begin
				peer.send(12'h4B4, 11);
				peer.send(12'h678, 11);
			end
			begin
				poll(2);
				apb(0, 12'h00C, 0);
				chk("rx first", 32'h5A, rq);
			end
		join
		poll(2);
		chk("rx errors", 32'h08, rq & 32'h18);
		apb(0, 12'h00C, 0);
		chk("rx second", 32'h3C, rq);
	endtask
	task test_done;
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_regs;
		t_formats;
		t_sync;
		t_fifo;
		t_rx;
		test_done;
	end
endmodule // tb
